// ==== rtl/modbus_slave_function_handler.sv ====
// request decoder, checker, statistics and master supervision
`timescale 1ns/1ps
// Functional notes
// RL1 - codes 01 import/export, 02 export only bit reads, at most 251 bytes
// RL2 - codes 03 import/export, 04 export only register reads, at most 250 bytes
// RL3 - code 05 writes one boolean to import area, one byte
// RL4 - code 06 writes one word to import area, two bytes
// RL5 - code 08 supports only sub-code 0, echoing the request
// RL6 - code 15 writes many booleans to import area, at most 247 bytes
// RL7 - code 16 writes many variables to import area, at most 246 bytes
// RL8 - code 23 writes then reads; request 242, response 250 bytes max
// RL9 - code 43 returns the identification objects
// RL10 - codes 03, 04, 16, 23 accept any data type
// RL11 - master supplies start address and count in every request
// RL12 - unsupported function code answers exception 1
// RL13 - range not ending on a variable boundary answers exception 2
// RL14 - bad field value such as length answers exception 3
// RL15 - only in run state are requests processed; otherwise silence
// RL16 - no request within monitoring time drops connection, input data per config
// RL17 - counters clear on counter-reset rising 0 to 1; above 1 counts as 1
// RL18 - count total, valid and rejected requests since reset or start-up
// RL19 - invalid counter counts exception answers only, not driver errors
// RL20 - count response timeouts
// RL21 - report maximum and average concurrent requests
// RL22 - serial link answers only its configured address 1..247
// RL23 - exception answer echoes code with top bit set plus exception code
module modbus_slave_function_handler
    import mb_slave_pkg::*;
#(
    parameter int MON_W = 32  // width of monitoring time in ms
) (
    input  wire logic            sys_clk,      // 25 mhz clock
    input  wire logic            rst,          // synchronous, active high
    input  wire logic            reqValid,     // pulse: header decoded by driver
    input  wire mb_req_t         req,          // decoded request header
    input  wire logic [7:0]      busAddr,      // configured serial address
    input  wire logic            runState,     // module is in run state
    input  wire logic [MON_W-1:0] monTimeMs,   // master monitoring time
    input  wire logic            holdLast,     // 1: keep inputs, 0: initial values
    input  wire logic [7:0]      counterReset, // reset-all-counters variable
    input  wire logic            respTimeout,  // pulse: ack not received in time
    input  wire logic [7:0]      concurrent,   // requests now being handled
    output mb_rsp_t              rsp,          // answer to the link
    output logic                 connected,    // master connection state
    output logic                 inputsInit,   // pulse: restore initial inputs
    output mb_stats_t            stats         // statistics counters
);

    // action one-hot bits
    localparam logic [3:0] ACT_READ  = 4'h1;
    localparam logic [3:0] ACT_WRITE = 4'h2;
    localparam logic [3:0] ACT_ECHO  = 4'h4;
    localparam logic [3:0] ACT_IDENT = 4'h8;

    typedef struct packed {
        mb_state_t        state;
        mb_req_t          hold;
        mb_rsp_t          rsp;
        mb_stats_t        stats;
        logic [MON_W-1:0] msCnt;
        logic [15:0]      subCnt;
        logic             connected;
        logic             inputsInit;
        logic             rstSeen;
        logic [15:0]      avgAcc;  // running average, scaled by 16
    } st_t;

    st_t stReg;
    st_t stNext;

    // ----------------------------------------------------------------
    // request checking
    // ----------------------------------------------------------------
    logic       known;
    logic       lenBad;
    logic       areaBad;
    logic [3:0] act;

    // code decode and length limits; limits compare byte counts so any data type fits
    always_comb begin
        known   = 1'b1;
        lenBad  = (stReg.hold.quantity == 16'h0000);            // [RL11]
        areaBad = 1'b0;
        act     = ACT_READ;
        unique case (stReg.hold.funcCode)
            FC_READ_COILS:    lenBad |= stReg.hold.readBytes > MAX_BITS_RD;  // [RL1]
            FC_READ_DISCRETE: begin
                lenBad |= stReg.hold.readBytes > MAX_BITS_RD;              // [RL1]
                areaBad = !stReg.hold.readExport;                         // [RL1]
            end
            FC_READ_HOLDING:  lenBad |= stReg.hold.readBytes > MAX_REGS_RD;  // [RL2] [RL10]
            FC_READ_INPUT:    begin
                lenBad |= stReg.hold.readBytes > MAX_REGS_RD;              // [RL2] [RL10]
                areaBad = !stReg.hold.readExport;                         // [RL2]
            end
            FC_WRITE_COIL:    begin
                lenBad |= stReg.hold.byteCount > MAX_COIL_WR;              // [RL3]
                act = ACT_WRITE;
            end
            FC_WRITE_REG:     begin
                lenBad |= stReg.hold.byteCount > MAX_REG_WR;               // [RL4]
                act = ACT_WRITE;
            end
            FC_DIAG:          begin
                lenBad = stReg.hold.startAddr != DIAG_SUB_ECHO;           // [RL5]
                act = ACT_ECHO;
            end
            FC_WRITE_COILS:   begin
                lenBad |= stReg.hold.byteCount > MAX_COILS_WR;             // [RL6]
                act = ACT_WRITE;
            end
            FC_WRITE_REGS:    begin
                lenBad |= stReg.hold.byteCount > MAX_REGS_WR;              // [RL7] [RL10]
                act = ACT_WRITE;
            end
            FC_READ_WRITE:    begin
                lenBad |= (stReg.hold.byteCount > MAX_RW_REQ)
                        || (stReg.hold.readBytes > MAX_RW_RSP);            // [RL8] [RL10]
                act = ACT_WRITE | ACT_READ;
            end
            FC_DEVICE_ID:     begin
                lenBad = 1'b0;
                act = ACT_IDENT;                                           // [RL9]
            end
            default:          begin
                known = 1'b0;                                              // [RL12]
                lenBad = 1'b0;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    logic addrMine;
    logic resetEdge;
    logic [7:0] excSel;

    assign addrMine  = !req.serial || (req.unitAddr == busAddr
                     && busAddr >= ADDR_MIN && busAddr <= ADDR_MAX);         // [RL22]
    assign resetEdge = (counterReset != 8'h00) && !stReg.rstSeen;            // [RL17]

    // exception priority: code, then area/boundary, then value
    always_comb begin
        if (!known)
            excSel = EXC_CODE;                                              // [RL12]
        else if (areaBad || !stReg.hold.boundaryOk)
            excSel = EXC_DATA;                                              // [RL13]
        else if (lenBad)
            excSel = EXC_VALUE;                                             // [RL14]
        else
            excSel = 8'h00;
    end

    always_comb begin
        stNext            = stReg;
        stNext.rsp.send   = 1'b0;
        stNext.inputsInit = 1'b0;
        stNext.rstSeen    = counterReset != 8'h00;

        // millisecond tick and master supervision
        if (stReg.subCnt == 16'(CYCLES_PER_MS - 1)) begin
            stNext.subCnt = 16'h0000;
            if (stReg.connected) begin
                if (stReg.msCnt + 1'b1 >= monTimeMs) begin
                    stNext.connected  = 1'b0;                              // [RL16]
                    stNext.inputsInit = !holdLast;                         // [RL16]
                end
                stNext.msCnt = stReg.msCnt + 1'b1;
            end
        end else begin
            stNext.subCnt = stReg.subCnt + 16'h0001;
        end

        if (respTimeout)
            stNext.stats.timeouts = stReg.stats.timeouts + 16'h0001;        // [RL20]
        if (concurrent > stReg.stats.maxConc)
            stNext.stats.maxConc = concurrent;                              // [RL21]
        // exponential average, weight 1/16; cheap and never overflows
        stNext.avgAcc = stReg.avgAcc - (stReg.avgAcc >> 4) + {8'h00, concurrent};
        stNext.stats.avgConc = stReg.avgAcc[11:4];                          // [RL21]

        unique case (stReg.state)
            ST_IDLE: begin
                if (reqValid && runState && addrMine) begin                 // [RL15] [RL22]
                    stNext.hold  = req;
                    stNext.state = ST_EVAL;
                    stNext.stats.total = stReg.stats.total + 16'h0001;      // [RL18]
                    stNext.connected = 1'b1;
                    stNext.msCnt     = '0;
                    // restart the ms phase too, else a drop could follow a request at once
                    stNext.subCnt    = 16'h0000;                            // [RL16]
                end
            end
            ST_EVAL: begin
                stNext.rsp.send = 1'b1;
                stNext.state    = ST_RESP;
                if (excSel != 8'h00) begin
                    stNext.rsp.funcCode = stReg.hold.funcCode | FC_EXC_FLAG; // [RL23]
                    stNext.rsp.excCode  = excSel;                            // [RL23]
                    stNext.rsp.isExc    = 1'b1;
                    stNext.rsp.action   = 4'h0;
                    stNext.stats.invalid  = stReg.stats.invalid + 16'h0001;   // [RL19]
                    stNext.stats.rejected = stReg.stats.rejected + 16'h0001;  // [RL18]
                end else begin
                    stNext.rsp.funcCode = stReg.hold.funcCode;
                    stNext.rsp.excCode  = 8'h00;
                    stNext.rsp.isExc    = 1'b0;
                    stNext.rsp.action   = act;
                    stNext.stats.valid  = stReg.stats.valid + 16'h0001;       // [RL18]
                end
            end
            ST_RESP: stNext.state = ST_IDLE;
        endcase

        // counter clear wins over any count in the same cycle
        if (resetEdge) begin
            stNext.stats.total    = CNT_RESET;                              // [RL17]
            stNext.stats.valid    = CNT_RESET;
            stNext.stats.invalid  = CNT_RESET;
            stNext.stats.rejected = CNT_RESET;
            stNext.stats.timeouts = CNT_RESET;
            stNext.stats.maxConc  = 8'h00;
        end
    end

    // state register
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            stReg       <= '0;
            stReg.state <= ST_IDLE;
        end else begin
            stReg <= stNext;
        end
    end

    assign rsp        = stReg.rsp;
    assign connected  = stReg.connected;
    assign inputsInit = stReg.inputsInit;
    assign stats      = stReg.stats;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    // short names for the evaluation cycle keep the checks readable
    logic    inEval;
    mb_req_t held;

    assign inEval = stReg.state == ST_EVAL;
    assign held   = stReg.hold;

    // every check runs on the system clock and sleeps through reset
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    // answer format and exception selection
    a_exc_flag_set: assert property (rsp.send && rsp.isExc |-> rsp.funcCode[7]) // [RL23]
        else $error("exception answer lacks top bit");
    a_unknown_code: assert property (inEval && !known // [RL12]
        |=> rsp.send && rsp.excCode == EXC_CODE)
        else $error("unknown code not answered with 1");
    a_boundary_bad: assert property (inEval && known && !held.boundaryOk // [RL13]
        |=> rsp.excCode == EXC_DATA)
        else $error("boundary fault not answered with 2");
    a_area_export: assert property (inEval && !held.readExport // [RL1] [RL2]
        && (held.funcCode == FC_READ_DISCRETE || held.funcCode == FC_READ_INPUT)
        |=> rsp.isExc && rsp.excCode == EXC_DATA)
        else $error("export-only code read the import area");
    a_len_bad_val: assert property (inEval && known && !areaBad // [RL14]
        && held.boundaryOk && lenBad |=> rsp.excCode == EXC_VALUE)
        else $error("length fault not answered with 3");
    a_diag_sub: assert property (inEval && held.funcCode == FC_DIAG // [RL5]
        && held.startAddr != DIAG_SUB_ECHO |=> rsp.isExc)
        else $error("diagnostics sub-code accepted");
    a_ident_act: assert property (inEval && held.funcCode == FC_DEVICE_ID // [RL9]
        && held.boundaryOk |=> rsp.action == ACT_IDENT && !rsp.isExc)
        else $error("identification not served");

    // process data limits: anything past a limit must be refused
    a_bits_rd_len: assert property (inEval && held.funcCode == FC_READ_COILS // [RL1]
        && held.readBytes > MAX_BITS_RD |=> rsp.isExc)
        else $error("bit read over limit");
    a_regs_rd_len: assert property (inEval && held.funcCode == FC_READ_HOLDING // [RL2]
        && held.readBytes > MAX_REGS_RD |=> rsp.isExc)
        else $error("register read over limit");
    a_coil_wr_len: assert property (inEval && held.funcCode == FC_WRITE_COIL // [RL3]
        && held.byteCount > MAX_COIL_WR |=> rsp.isExc)
        else $error("coil write over limit");
    a_reg_wr_len: assert property (inEval && held.funcCode == FC_WRITE_REG // [RL4]
        && held.byteCount > MAX_REG_WR |=> rsp.isExc)
        else $error("register write over limit");
    a_coils_wr_len: assert property (inEval && held.funcCode == FC_WRITE_COILS // [RL6]
        && held.byteCount > MAX_COILS_WR |=> rsp.isExc)
        else $error("coils write over limit");
    a_regs_wr_len: assert property (inEval && held.funcCode == FC_WRITE_REGS // [RL7]
        && held.byteCount > MAX_REGS_WR |=> rsp.isExc)
        else $error("registers write over limit");
    a_rw_len: assert property (inEval && held.funcCode == FC_READ_WRITE // [RL8]
        && (held.byteCount > MAX_RW_REQ || held.readBytes > MAX_RW_RSP) |=> rsp.isExc)
        else $error("read-write over limit");

    // link state, silence and address filter
    // a refused request must leave no trace on the answer for two cycles
    a_no_run_silent: assert property (reqValid && !runState && stReg.state == ST_IDLE // [RL15]
        |=> stReg.state == ST_IDLE && !rsp.send ##1 !rsp.send)
        else $error("answer outside run state");
    a_wrong_addr: assert property (reqValid && req.serial && req.unitAddr != busAddr // [RL22]
        && stReg.state == ST_IDLE |=> stReg.state == ST_IDLE)
        else $error("foreign address accepted");
    a_taken_conn: assert property (stReg.state == ST_IDLE && reqValid && runState // [RL16]
        && addrMine |=> connected [*8])
        else $error("link not held after a request");
    a_init_on_drop: assert property (inputsInit // [RL16]
        |-> $fell(connected) && !$past(holdLast))
        else $error("initial values restored without a drop");
    a_drop_init: assert property ($fell(connected) && !$past(holdLast) |-> inputsInit) // [RL16]
        else $error("initial values not restored on drop");

    // statistics counters
    a_cnt_clear: assert property ($rose(counterReset != 8'h00) // [RL17]
        |=> stats.total == 16'h0000)
        else $error("counters not cleared");
    a_total_step: assert property (stReg.state == ST_IDLE && reqValid && runState // [RL18]
        && addrMine && !resetEdge |=> stats.total == $past(stats.total) + 16'h0001)
        else $error("total not counted");
    a_invalid_cnt: assert property (rsp.send && !$past(resetEdge) // [RL19]
        |-> stats.invalid == $past(stats.invalid) + 16'(rsp.isExc))
        else $error("invalid count mismatch");
    a_timeout_cnt: assert property (respTimeout && !resetEdge // [RL20]
        |=> stats.timeouts == $past(stats.timeouts) + 16'h0001)
        else $error("timeout not counted");
    a_max_conc: assert property (!resetEdge |=> stats.maxConc >= $past(concurrent)) // [RL21]
        else $error("maximum below observed");

    // main scenarios
    c_valid_read: cover property (rsp.send && !rsp.isExc && rsp.action == ACT_READ);
    c_exception:  cover property (rsp.send && rsp.isExc);
    c_disconnect: cover property ($fell(connected));
    c_cnt_reset:  cover property (resetEdge && stats.total != 16'h0000);
    c_silent:     cover property (reqValid && !runState);

endmodule // modbus_slave_function_handler

// ==== rtl/mb_slave_pkg.sv ====
// package: constants, codes and carrier types of the request handler
package mb_slave_pkg;

    // function codes
    localparam logic [7:0] FC_READ_COILS    = 8'h01;
    localparam logic [7:0] FC_READ_DISCRETE = 8'h02;
    localparam logic [7:0] FC_READ_HOLDING  = 8'h03;
    localparam logic [7:0] FC_READ_INPUT    = 8'h04;
    localparam logic [7:0] FC_WRITE_COIL    = 8'h05;
    localparam logic [7:0] FC_WRITE_REG     = 8'h06;
    localparam logic [7:0] FC_DIAG          = 8'h08;
    localparam logic [7:0] FC_WRITE_COILS   = 8'h0F;
    localparam logic [7:0] FC_WRITE_REGS    = 8'h10;
    localparam logic [7:0] FC_READ_WRITE    = 8'h17;
    localparam logic [7:0] FC_DEVICE_ID     = 8'h2B;
    localparam logic [7:0] FC_EXC_FLAG      = 8'h80;

    // exception codes
    localparam logic [7:0] EXC_CODE  = 8'h01;
    localparam logic [7:0] EXC_DATA  = 8'h02;
    localparam logic [7:0] EXC_VALUE = 8'h03;

    // process data limits in bytes
    localparam logic [15:0] MAX_BITS_RD    = 16'h00FB; // 251
    localparam logic [15:0] MAX_REGS_RD    = 16'h00FA; // 250
    localparam logic [15:0] MAX_COIL_WR    = 16'h0001; // 1
    localparam logic [15:0] MAX_REG_WR     = 16'h0002; // 2
    localparam logic [15:0] MAX_COILS_WR   = 16'h00F7; // 247
    localparam logic [15:0] MAX_REGS_WR    = 16'h00F6; // 246
    localparam logic [15:0] MAX_RW_REQ     = 16'h00F2; // 242
    localparam logic [15:0] MAX_RW_RSP     = 16'h00FA; // 250
    localparam logic [15:0] DIAG_SUB_ECHO  = 16'h0000;

    // bus address range
    localparam logic [7:0] ADDR_MIN = 8'h01;
    localparam logic [7:0] ADDR_MAX = 8'hF7; // 247

    // timing
    localparam int CLK_HZ        = 25_000_000;
    localparam int MS_NS         = 1_000_000;
    localparam int CYCLES_PER_MS = CLK_HZ / 1000;

    localparam logic [15:0] CNT_RESET = 16'h0000;

    // decoded request header
    typedef struct packed {
        logic [7:0]  unitAddr;  // serial bus address, ignored on tcp
        logic [7:0]  funcCode;
        logic [15:0] startAddr; // diag: sub-code
        logic [15:0] quantity;  // bits or registers; diag: echo data
        logic [15:0] byteCount; // process bytes carried by the request
        logic [15:0] readBytes; // process bytes the response would carry
        logic        boundaryOk; // range ends on a variable boundary
        logic        readExport; // access targets the export area
        logic        serial;     // arrived on the serial link
    } mb_req_t;

    // answer to the link
    typedef struct packed {
        logic        send;
        logic [7:0]  funcCode;
        logic [7:0]  excCode;
        logic        isExc;
        logic [3:0]  action;    // area accesses to start, one bit each; code 23 sets two
    } mb_rsp_t;

    // statistics
    typedef struct packed {
        logic [15:0] total;
        logic [15:0] valid;
        logic [15:0] invalid;
        logic [15:0] rejected;
        logic [15:0] timeouts;
        logic [7:0]  maxConc;
        logic [7:0]  avgConc;
    } mb_stats_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_EVAL = 3'b010,
        ST_RESP = 3'b100
    } mb_state_t;

endpackage

// ==== tb/mb_master_model.sv ====
// behavioural master: issues decoded request headers to the handler
`timescale 1ns/1ps
module mb_master_model
    import mb_slave_pkg::*;
(
    input  wire logic sys_clk,  // bench clock
    output logic      reqValid, // one-cycle request pulse
    output mb_req_t   req       // decoded request header
);
    // ----------------------------------------
    // request issue
    // ----------------------------------------
    initial begin
        reqValid = 1'b0;
        req      = '0;
    end

    // every header carries start address and count
    // driven just after an edge, held through the taking edge
    task automatic send(input mb_req_t r);
        @(posedge sys_clk);
        #1;
        req      = r;
        reqValid = 1'b1;
        @(posedge sys_clk);
        #1;
        reqValid = 1'b0;
        req      = ~r; // released header shows junk, never the last value
    endtask
endmodule // mb_master_model

// ==== tb/modbus_slave_function_handler_test.sv ====
// self-checking bench of the request handler
`timescale 1ns/1ps
module modbus_slave_function_handler_test
    import mb_slave_pkg::*;
;
    logic        sys_clk = 1'b0;
    logic        rst = 1'b1;
    logic        reqValid;
    mb_req_t     req;
    logic [7:0]  busAddr = 8'h11;
    logic        runState = 1'b1;
    logic [31:0] monTimeMs = 32'h0000_0001;
    logic        holdLast = 1'b0;
    logic [7:0]  counterReset = 8'h00;
    logic        respTimeout = 1'b0;
    logic [7:0]  concurrent = 8'h00;
    mb_rsp_t     rsp;
    logic        connected;
    logic        inputsInit;
    mb_stats_t   stats;
    int          miscompares = 0;
    int          cmp_count = 0;
    int          cycles = 0;
    logic [15:0] expTot = 0, expVal = 0, expInv = 0;

    // ----------------------------------------
    // clock, watchdog, instances
    // ----------------------------------------
    always #20 sys_clk = ~sys_clk;

    // the monitor scenarios dominate the run; ceiling leaves slack above them
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 90000) begin
            miscompares++;
            report_and_stop();
        end
    end

    mb_master_model m_u (.sys_clk(sys_clk), .reqValid(reqValid), .req(req));

    modbus_slave_function_handler dut_u (
        .sys_clk(sys_clk), .rst(rst), .reqValid(reqValid), .req(req),
        .busAddr(busAddr), .runState(runState), .monTimeMs(monTimeMs),
        .holdLast(holdLast), .counterReset(counterReset), .respTimeout(respTimeout),
        .concurrent(concurrent), .rsp(rsp), .connected(connected),
        .inputsInit(inputsInit), .stats(stats)
    );

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic report_and_stop();
        if (miscompares == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // unit address stays inside 1..247 unless a scenario says otherwise
    function automatic mb_req_t mk(logic [7:0] fc, logic [15:0] wr, logic [15:0] rd);
        mk            = '0;
        mk.unitAddr   = 8'h11;
        mk.funcCode   = fc;
        mk.quantity   = 16'h0001;
        mk.byteCount  = wr;
        mk.readBytes  = rd;
        mk.boundaryOk = 1'b1;
        mk.readExport = 1'b1;
        mk.serial     = 1'b1;
    endfunction

    // answer is launched by the edge after the taking edge and stands one cycle
    task automatic run(input mb_req_t r, input logic sent, input logic [7:0] exc,
                       input logic [3:0] act);
        m_u.send(r);
        chk(16'(rsp.send), 16'h0000);
        @(posedge sys_clk);
        #1;
        chk(16'(rsp.send), 16'(sent));
        if (sent) begin
            expTot++;
            chk(16'(rsp.isExc), 16'(exc != 8'h00));
            if (exc != 8'h00) begin
                expInv++;
                chk(16'(rsp.funcCode), 16'(r.funcCode | FC_EXC_FLAG));
                chk(16'(rsp.excCode), 16'(exc));
            end else begin
                expVal++;
                chk(16'(rsp.funcCode), 16'(r.funcCode));
                chk(16'(rsp.action), 16'(act));
            end
        end
        chk(stats.total, expTot);
        chk(stats.valid, expVal);
        chk(stats.invalid, expInv);
        chk(stats.rejected, expInv);
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    // every code at its limit, then one byte over; 08 and 2B have no limit and run once
    task automatic t_codes();
        logic [7:0]  fc [11] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h08,
                                 8'h0F, 8'h10, 8'h17, 8'h2B};
        logic [15:0] wr [11] = '{0, 0, 0, 0, 1, 2, 0, 247, 246, 242, 0};
        logic [15:0] rd [11] = '{251, 251, 250, 250, 0, 0, 0, 0, 0, 250, 0};
        logic [3:0]  ac [11] = '{1, 1, 1, 1, 2, 2, 4, 2, 2, 3, 8};
        for (int i = 0; i < 11; i++) begin
            run(mk(fc[i], wr[i], rd[i]), 1'b1, 8'h00, ac[i]);
            if (wr[i] != 0) run(mk(fc[i], wr[i] + 1, rd[i]), 1'b1, EXC_VALUE, 0);
            if (rd[i] != 0) run(mk(fc[i], wr[i], rd[i] + 1), 1'b1, EXC_VALUE, 0);
        end
    endtask

    task automatic t_exc();
        mb_req_t r;
        run(mk(8'h07, 0, 0), 1'b1, EXC_CODE, 0);
        r = mk(8'h41, 0, 0);
        r.boundaryOk = 1'b0;
        run(r, 1'b1, EXC_CODE, 0);
        r = mk(FC_READ_HOLDING, 0, 4);
        r.boundaryOk = 1'b0;
        run(r, 1'b1, EXC_DATA, 0);
        r.boundaryOk = 1'b1;
        r.quantity = 16'h0000;
        run(r, 1'b1, EXC_VALUE, 0);
        for (int i = 1; i <= 4; i++) begin
            r = mk(8'(i), 0, 4);
            r.readExport = 1'b0;
            run(r, 1'b1, (i[0] ? 8'h00 : EXC_DATA), 1);
        end
        r = mk(FC_DIAG, 0, 0);
        r.startAddr = 16'h0001;
        run(r, 1'b1, EXC_VALUE, 0);
    endtask

    task automatic t_silent();
        mb_req_t r;
        runState = 1'b0;
        run(mk(FC_READ_COILS, 0, 2), 1'b0, 8'h00, 0);
        runState = 1'b1;
        r = mk(FC_READ_COILS, 0, 2);
        r.unitAddr = 8'h12;
        run(r, 1'b0, 8'h00, 0);
        r.serial = 1'b0;
        run(r, 1'b1, 8'h00, 1);
    endtask

    task automatic t_counters();
        respTimeout = 1'b1;
        @(posedge sys_clk);
        #1;
        respTimeout = 1'b0;
        repeat (2) @(posedge sys_clk);
        #1;
        chk(stats.timeouts, 16'h0001);
        concurrent = 8'h07;
        repeat (3) @(posedge sys_clk);
        #1;
        concurrent = 8'h02;
        repeat (2) @(posedge sys_clk);
        #1;
        chk(16'(stats.maxConc), 16'h0007);
        counterReset = 8'h05; // values above one act as one
        repeat (2) @(posedge sys_clk);
        #1;
        expTot = 0;
        expVal = 0;
        expInv = 0;
        chk(stats.timeouts, 16'h0000);
        run(mk(FC_READ_COILS, 0, 2), 1'b1, 8'h00, 1);
        counterReset = 8'h00;
    endtask

    // drop of the master link after one quiet millisecond
    task automatic t_monitor(input logic keep);
        int n = 0;
        logic seen = 1'b0;
        holdLast = keep;
        run(mk(FC_READ_COILS, 0, 2), 1'b1, 8'h00, 1);
        chk(16'(connected), 16'h0001);
        while (connected === 1'b1 && n < 26000) begin
            @(posedge sys_clk);
            #1;
            n++;
            if (inputsInit === 1'b1) seen = 1'b1;
        end
        @(posedge sys_clk);
        #1;
        if (inputsInit === 1'b1) seen = 1'b1;
        chk(16'(n > 24000 && n < 26000), 16'h0001);
        chk(16'(seen), 16'(!keep));
        chk(16'(stats.avgConc), 16'h0002); // a steady load averages to itself
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        repeat (3) @(posedge sys_clk);
        #1;
        rst = 1'b0;
        chk(16'(connected), 16'h0000);
        chk(stats.total, 16'h0000);
        t_codes();
        t_exc();
        t_silent();
        t_counters();
        t_monitor(1'b0);
        t_monitor(1'b1);
        report_and_stop();
    end
endmodule // modbus_slave_function_handler_test
